// ### afc_bp_timer.sv
// back-pressure duration timer, restartable
`timescale 1ns/10ps
`default_nettype none
module afc_bp_timer import afc_pkg::*; #(
   parameter logic [11:0] UNIT_CYCLES = 12'd500,
   parameter logic [11:0] SLOW_EXTRA_CYCLES = 12'd220
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic [3:0] code_i,
   input wire logic slow_i,
   output logic busy_o
);

   logic [11:0] ext_cnt;
   logic [11:0] pre_cnt;
   logic [6:0] units_left;

   // extra 10 Mbps time first, then whole 5 us units
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ext_cnt <= 12'h000;
         pre_cnt <= 12'h000;
         units_left <= 7'h00;
      end else if (start_i) begin
         ext_cnt <= slow_i ? SLOW_EXTRA_CYCLES : 12'h000;
         units_left <= afc_unit_mult(code_i);
         pre_cnt <= UNIT_CYCLES - 12'h001;
      end else if (ext_cnt != 12'h000) begin
         ext_cnt <= ext_cnt - 12'h001;
      end else if (units_left != 7'h00) begin
         if (pre_cnt == 12'h000) begin
            pre_cnt <= UNIT_CYCLES - 12'h001;
            units_left <= units_left - 7'h01;
         end else begin
            pre_cnt <= pre_cnt - 12'h001;
         end
      end
   end

   // expiry ends the jam on its own
   assign busy_o = (ext_cnt != 12'h000) | (units_left != 7'h00);

endmodule : afc_bp_timer
`default_nettype wire

// ### afc_flow_ctrl.sv
// receive fifo automatic flow control with apb register slave
`timescale 1ns/10ps
`default_nettype none
`include "afc_regs.svh"
module afc_flow_ctrl import afc_pkg::*; #(
   parameter logic [11:0] BP_UNIT_CYCLES = 12'(`AFC_BP_UNIT_CYCLES),
   parameter logic [11:0] BP_SLOW_EXTRA_CYCLES = 12'(`AFC_BP_SLOW_EXTRA_CYCLES)
) (
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [3:0] PSTRB_I,
   output var logic [31:0] PRDATA_O,
   output var logic PREADY_O,
   output var logic PSLVERR_O,
   input wire logic FULL_DUPLEX_I,
   input wire logic SPEED_100_I,
   input wire logic TX_ENABLE_I,
   input wire afc_fifo_evt_s FIFO_EVT_I,
   input wire afc_rx_evt_s RX_EVT_I,
   input wire logic PAUSE_ACK_I,
   output var afc_pause_s PAUSE_O,
   output var logic JAM_O
);

   // round a frame length up to a whole dword
   function automatic logic [15:0] rnd_dword(input logic [15:0] len);
      logic [16:0] s;
      s = {1'b0, len} + 17'h00003;
      return {s[15:2], 2'b00};
   endfunction : rnd_dword

   // threshold field to a byte level
   function automatic logic [15:0] th_bytes(input logic [7:0] th);
      return {2'b00, th, 6'h00};
   endfunction : th_bytes

   // merge write data under byte strobes
   function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return r;
   endfunction : apply_strb

   logic [`AUTO_FLOW_CONTROL_CONFIG_W-1:0] cfg;
   logic [15:0] pause_time_value;
   logic [15:0] rx_fifo_used_bytes;
   afc_state_e state;
   afc_state_e next_state;
   logic bp_busy;

   // configuration fields
   wire [7:0] flow_high_threshold = cfg[`FLOW_HIGH_THRESHOLD_LSB +: 8];
   wire [7:0] flow_low_threshold = cfg[`FLOW_LOW_THRESHOLD_LSB +: 8];
   wire [3:0] jam_duration_select = cfg[`AFC_DUR_LSB +: 4];
   wire jam_on_multicast_en = cfg[`AFC_MCAST_BIT];
   wire jam_on_broadcast_en = cfg[`AFC_BCAST_BIT];
   wire jam_on_own_address_en = cfg[`AFC_OWN_BIT];
   wire flow_on_any_frame_en = cfg[`AFC_ANY_BIT];

   // threshold compares; a zero high threshold means always reached
   wire hi_reached = rx_fifo_used_bytes >= th_bytes(flow_high_threshold);
   wire lo_below = rx_fifo_used_bytes < th_bytes(flow_low_threshold);

   // apb phase and address decode
   wire apb_setup = PSEL_I & ~PENABLE_I;
   wire apb_xfer = PSEL_I & PENABLE_I & PREADY_O;
   wire hit_cfg = (PADDR_I == `AUTO_FLOW_CONTROL_CONFIG_OFS);
   wire hit_ptime = (PADDR_I == `AFC_PTIME_OFS);
   wire hit_stat = (PADDR_I == `AFC_STAT_OFS);
   wire hit_any = hit_cfg | hit_ptime | hit_stat;
   wire wr_cfg = apb_xfer & PWRITE_I & hit_cfg;
   wire wr_ptime = apb_xfer & PWRITE_I & hit_ptime;
   wire [31:0] cfg_word = {8'h00, cfg};
   wire [31:0] ptime_word = {16'h0000, pause_time_value};
   wire paused_flag = (state == FC_PAUSED) | (state == FC_RESUME_PEND);
   wire [31:0] stat_word = {13'h0000, hi_reached, JAM_O, paused_flag, rx_fifo_used_bytes};
   wire [31:0] rd_mux = hit_cfg ? cfg_word :
                        hit_ptime ? ptime_word :
                        hit_stat ? stat_word : 32'h00000000;
   wire [31:0] cfg_merged = apply_strb(cfg_word, PWDATA_I, PSTRB_I);
   wire [31:0] ptime_merged = apply_strb(ptime_word, PWDATA_I, PSTRB_I);

   // one wait-free access phase: answer prepared in the setup cycle
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         PREADY_O <= 1'b0;
         PSLVERR_O <= 1'b0;
         PRDATA_O <= 32'h00000000;
      end else begin
         PREADY_O <= apb_setup;
         PSLVERR_O <= apb_setup & ~hit_any;
         PRDATA_O <= (apb_setup & ~PWRITE_I) ? rd_mux : 32'h00000000;
      end
   end

   // software registers, written only at the completing edge
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         cfg <= `AUTO_FLOW_CONTROL_CONFIG_RST;
         pause_time_value <= `AFC_PTIME_RST;
      end else begin
         if (wr_cfg) begin
            cfg <= cfg_merged[`AUTO_FLOW_CONTROL_CONFIG_W-1:0];
         end
         if (wr_ptime) begin
            pause_time_value <= ptime_merged[15:0];
         end
      end
   end

   // fill level: add rounded frame length, subtract drained bytes, clamp both ends
   wire [15:0] add_bytes = FIFO_EVT_I.commit ? rnd_dword(FIFO_EVT_I.commit_len) : 16'h0000;
   wire [15:0] sub_bytes = FIFO_EVT_I.drain ? FIFO_EVT_I.drain_bytes : 16'h0000;
   wire [16:0] lvl_sum = {1'b0, rx_fifo_used_bytes} + {1'b0, add_bytes};
   wire [15:0] lvl_sat = lvl_sum[16] ? 16'hffff : lvl_sum[15:0];
   wire [15:0] next_level = (lvl_sat > sub_bytes) ? (lvl_sat - sub_bytes) : 16'h0000;

   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         rx_fifo_used_bytes <= 16'h0000;
      end else begin
         rx_fifo_used_bytes <= next_level;
      end
   end

   // full duplex needs only the any-frame enable; class bits are ignored there
   wire fd_active = FULL_DUPLEX_I & flow_on_any_frame_en;
   wire pause_taken = PAUSE_O.req & PAUSE_ACK_I;

   // pause sequencer: one pause per crossing, resume only from paused
   always_comb begin
      next_state = state;
      case (state)
         FC_IDLE: begin
            if (fd_active & hi_reached) begin
               next_state = FC_PAUSE_PEND;
            end
         end
         FC_PAUSE_PEND: begin
            if (pause_taken) begin
               next_state = FC_PAUSED;
            end else if (~fd_active) begin
               next_state = FC_IDLE;
            end
         end
         FC_PAUSED: begin
            if (fd_active & lo_below) begin
               next_state = FC_RESUME_PEND;
            end
         end
         FC_RESUME_PEND: begin
            if (pause_taken) begin
               next_state = FC_IDLE;
            end
         end
         default: next_state = FC_IDLE;
      endcase
   end

   // request held until the MAC queues it; muted while the transmitter is off
   wire next_req = ((next_state == FC_PAUSE_PEND) | (next_state == FC_RESUME_PEND))
                   & TX_ENABLE_I;
   wire [15:0] next_ptime = (next_state == FC_RESUME_PEND) ? 16'h0000 : pause_time_value;

   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         state <= FC_IDLE;
         PAUSE_O <= '0;
      end else begin
         state <= next_state;
         PAUSE_O.req <= next_req;
         PAUSE_O.pause_time <= next_ptime;
      end
   end

   // half duplex frame classing; any-frame acts on preamble, no address decode
   wire hd_active = ~FULL_DUPLEX_I & TX_ENABLE_I;
   wire class_hit = (jam_on_multicast_en & RX_EVT_I.mcast)
                  | (jam_on_broadcast_en & RX_EVT_I.bcast)
                  | (jam_on_own_address_en & RX_EVT_I.own_match);
   wire frame_hit = flow_on_any_frame_en ? RX_EVT_I.preamble
                                         : (RX_EVT_I.addr_done & class_hit);
   wire bp_start = hd_active & hi_reached & frame_hit;

   afc_bp_timer #(
      .UNIT_CYCLES(BP_UNIT_CYCLES),
      .SLOW_EXTRA_CYCLES(BP_SLOW_EXTRA_CYCLES)
   ) u_bp_timer (
      .clk_i(CLK_I),
      .rst_i(SYS_RST_I),
      .start_i(bp_start),
      .code_i(jam_duration_select),
      .slow_i(~SPEED_100_I),
      .busy_o(bp_busy)
   );

   // jam output registered; dropping duplex or transmitter cuts it one cycle later
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         JAM_O <= 1'b0;
      end else begin
         JAM_O <= bp_busy & hd_active;
      end
   end

   // checking helpers: busy length since last start and its expected value
   logic [16:0] bp_cnt;
   logic [16:0] bp_exp;
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         bp_cnt <= 17'h00000;
         bp_exp <= 17'h00000;
      end else if (bp_start) begin
         bp_cnt <= 17'h00000;
         bp_exp <= (SPEED_100_I ? 17'h00000 : 17'(BP_SLOW_EXTRA_CYCLES))
                   + 17'(afc_unit_mult(jam_duration_select)) * 17'(BP_UNIT_CYCLES);
      end else if (bp_busy) begin
         bp_cnt <= bp_cnt + 17'h00001;
      end
   end

   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (SYS_RST_I);

   // threshold crossing requests a pause with the programmed time
   AST_HI_PAUSE: assert property ((state == FC_IDLE) & fd_active & hi_reached & TX_ENABLE_I
      |=> PAUSE_O.req && (PAUSE_O.pause_time == $past(pause_time_value)))
      else $error("no pause request after high threshold");

   // no second pause while paused
   AST_ONE_PAUSE: assert property ((state == FC_PAUSED) |-> !PAUSE_O.req)
      else $error("pause requested again while paused");

   // resume frame carries zero time
   AST_RESUME_ZERO: assert property (PAUSE_O.req && (state == FC_RESUME_PEND)
      |-> (PAUSE_O.pause_time == 16'h0000))
      else $error("resume pause time not zero");

   // resume only entered from paused
   AST_RESUME_GATED: assert property ($rose(state == FC_RESUME_PEND)
      |-> $past(state == FC_PAUSED))
      else $error("resume without prior pause");

   // transmitter off silences both outputs
   AST_TX_OFF: assert property (!TX_ENABLE_I |=> !PAUSE_O.req && !JAM_O)
      else $error("activity while transmitter disabled");

   // qualifying frame turns jam on two cycles later
   AST_JAM_START: assert property (bp_start ##1 hd_active |-> ##1 JAM_O)
      else $error("jam not started");

   // no jam in full duplex
   AST_FD_NO_JAM: assert property (FULL_DUPLEX_I |=> !JAM_O)
      else $error("jam in full duplex");

   // any-frame mode ignores address-decode results
   AST_ANY_OVERRIDE: assert property (flow_on_any_frame_en && !RX_EVT_I.preamble
      |-> !bp_start)
      else $error("class enables used with any-frame set");

   // jam timer runs exactly the coded duration
   AST_JAM_LEN: assert property ($fell(bp_busy) |-> (bp_cnt == bp_exp))
      else $error("jam duration wrong");

   // level grows by the dword-rounded length
   AST_LEVEL_ROUND: assert property (FIFO_EVT_I.commit && !FIFO_EVT_I.drain
      && (rx_fifo_used_bytes < 16'hf000) && (FIFO_EVT_I.commit_len < 16'h0f00)
      |=> rx_fifo_used_bytes == $past(rx_fifo_used_bytes) + rnd_dword($past(FIFO_EVT_I.commit_len)))
      else $error("fill level not dword rounded");

   // a drain alone lowers the level by the drained bytes
   AST_LEVEL_DRAIN: assert property (FIFO_EVT_I.drain && !FIFO_EVT_I.commit
      && (rx_fifo_used_bytes > FIFO_EVT_I.drain_bytes)
      |=> rx_fifo_used_bytes == $past(rx_fifo_used_bytes) - $past(FIFO_EVT_I.drain_bytes))
      else $error("fill level not lowered by drain");

   // dropping below the low level while paused asks for a zero-time frame
   AST_RESUME_REQ: assert property ((state == FC_PAUSED) & fd_active & lo_below & TX_ENABLE_I
      |=> PAUSE_O.req && (PAUSE_O.pause_time == 16'h0000))
      else $error("no resume request below low threshold");

   // without the any-frame enable no pause is ever started
   AST_ANY_GATES_PAUSE: assert property ((state == FC_IDLE) && !flow_on_any_frame_en
      |=> !PAUSE_O.req)
      else $error("pause requested without any-frame enable");

   // expiry of the timer ends the jam one cycle later
   AST_JAM_STOP: assert property ($fell(bp_busy) |=> !JAM_O)
      else $error("jam outlived its timer");

   // main scenarios
   COV_PAUSE_SENT: cover property (pause_taken && (state == FC_PAUSE_PEND));
   COV_RESUME_SENT: cover property (pause_taken && (state == FC_RESUME_PEND));
   COV_JAM_RESTART: cover property (bp_start && bp_busy);
   COV_SLOW_JAM: cover property ($fell(bp_busy) && !SPEED_100_I);
   COV_CLASS_JAM: cover property (bp_start && !flow_on_any_frame_en);

endmodule : afc_flow_ctrl
`default_nettype wire

// ### afc_mac_model.sv
// mac transmitter model: takes pause requests after a programmable queue delay
`timescale 1ns/10ps
`default_nettype none
module afc_mac_model import afc_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire afc_pause_s pause_i,
   input wire logic [3:0] delay_i,
   output logic ack_o
);
   logic [3:0] wait_cnt;

   // queue the request, accept it once the transmit window opens
   // ack is one cycle only so a request left standing is seen twice
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wait_cnt <= 4'h0;
         ack_o <= 1'b0;
      end else if (!pause_i.req || ack_o) begin
         wait_cnt <= 4'h0;
         ack_o <= 1'b0;
      end else if (wait_cnt >= delay_i) begin
         ack_o <= 1'b1;
      end else begin
         wait_cnt <= wait_cnt + 4'h1;
      end
   end
endmodule : afc_mac_model
`default_nettype wire

// ### afc_pkg.sv
// types and shared functions of the flow controller
package afc_pkg;

   // one-hot full-duplex pause sequencer states
   typedef enum logic [3:0] {
      FC_IDLE = 4'b0001,
      FC_PAUSE_PEND = 4'b0010,
      FC_PAUSED = 4'b0100,
      FC_RESUME_PEND = 4'b1000
   } afc_state_e;

   // receive-side frame events from the MAC
   typedef struct packed {
      logic preamble;
      logic addr_done;
      logic mcast;
      logic bcast;
      logic own_match;
   } afc_rx_evt_s;

   // receive fifo write and drain events
   typedef struct packed {
      logic commit;
      logic [15:0] commit_len;
      logic drain;
      logic [15:0] drain_bytes;
   } afc_fifo_evt_s;

   // pause request toward the MAC transmitter
   typedef struct packed {
      logic req;
      logic [15:0] pause_time;
   } afc_pause_s;

   // jam duration in 5 us units for a duration code
   function automatic logic [6:0] afc_unit_mult(input logic [3:0] code);
      logic [6:0] m;
      m = 7'd0;
      case (code)
         4'h0: m = 7'd1;
         4'h1: m = 7'd2;
         4'h2: m = 7'd3;
         4'h3: m = 7'd5;
         default: m = 7'({3'b000, code} - 7'd3) * 7'd10;
      endcase
      return m;
   endfunction : afc_unit_mult

endpackage : afc_pkg

// ### afc_regs.svh
// register map, field positions, reset values and timing counts of the flow controller
`ifndef AFC_REGS_SVH
`define AFC_REGS_SVH

// byte offsets on the register bus
`define AUTO_FLOW_CONTROL_CONFIG_OFS 12'h02c
`define AFC_PTIME_OFS 12'h100
`define AFC_STAT_OFS 12'h104

// configuration register fields and reset
`define AUTO_FLOW_CONTROL_CONFIG_W 24
`define AUTO_FLOW_CONTROL_CONFIG_RST 24'h000000
`define FLOW_HIGH_THRESHOLD_LSB 16
`define FLOW_LOW_THRESHOLD_LSB 8
`define AFC_DUR_LSB 4
`define AFC_MCAST_BIT 3
`define AFC_BCAST_BIT 2
`define AFC_OWN_BIT 1
`define AFC_ANY_BIT 0

// pause time register reset
`define AFC_PTIME_RST 16'h0000

// status register fields
`define AFC_STAT_PAUSED_BIT 16
`define AFC_STAT_JAM_BIT 17
`define AFC_STAT_HI_BIT 18

// threshold granularity as a shift: 64 bytes
`define AFC_TH_SHIFT 6

// timing: clock period, jam base unit, extra time at 10 Mbps
`define AFC_CLK_NS 10
`define AFC_BP_UNIT_NS 5000
`define AFC_BP_SLOW_EXTRA_NS 2200
`define AFC_BP_UNIT_CYCLES ((`AFC_BP_UNIT_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS)
`define AFC_BP_SLOW_EXTRA_CYCLES ((`AFC_BP_SLOW_EXTRA_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS)

`endif

// ### rx_fifo_flow_control_bench.sv
// self-checking bench of the receive fifo flow controller
`timescale 1ns/10ps
`default_nettype none
`include "afc_regs.svh"
module rx_fifo_flow_control_bench import afc_pkg::*; ;
   localparam int UNIT = 4;
   localparam int EXTRA = 3;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] prdata;
   logic pready, pslverr, ack, jam;
   logic fdx = 1'b0;
   logic spd = 1'b1;
   logic txen = 1'b0;
   logic [3:0] dly = 4'h2;
   afc_fifo_evt_s fifo = '0;
   afc_rx_evt_s rx = '0;
   afc_pause_s pause;
   int num_errors = 0;
   int n_compared = 0;
   int seed = 19093;
   int len;
   logic [31:0] q, d;
   logic e;
   logic [15:0] t;

   always #5 clk = ~clk;

   afc_flow_ctrl #(.BP_UNIT_CYCLES(12'h004), .BP_SLOW_EXTRA_CYCLES(12'h003)) u_dut (
      .CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .FULL_DUPLEX_I(fdx), .SPEED_100_I(spd),
      .TX_ENABLE_I(txen), .FIFO_EVT_I(fifo), .RX_EVT_I(rx), .PAUSE_ACK_I(ack),
      .PAUSE_O(pause), .JAM_O(jam));

   afc_mac_model u_mac (.clk_i(clk), .rst_i(rst), .pause_i(pause), .delay_i(dly), .ack_o(ack));

   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         num_errors++;
      end
   endtask : chk

   task automatic timeout(input string what);
      $display("wrong value %s expected answer seen none", what);
      num_errors++;
      report_and_stop();
   endtask : timeout

   // one apb transfer, request held until ready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int n;
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) timeout("apb ready");
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic pulse_fifo(input logic [15:0] cl, input logic [15:0] dl);
      fifo <= '{commit: cl != 0, commit_len: cl, drain: dl != 0, drain_bytes: dl};
      @(posedge clk);
      fifo <= '0;
      @(posedge clk);
   endtask : pulse_fifo

   // wait for a pause request, check its time, wait for it to be taken
   task automatic wait_req(input logic [15:0] exp_t);
      int n;
      n = 0;
      while (pause.req !== 1'b1) begin
         @(posedge clk);
         if (++n > 50) timeout("pause request");
      end
      chk("pause time", exp_t, pause.pause_time);
      while (pause.req === 1'b1) begin
         @(posedge clk);
         if (++n > 100) timeout("pause release");
      end
   endtask : wait_req

   task automatic quiet(input int n);
      repeat (n) begin
         @(posedge clk);
         chk("request and jam", 32'h0, {pause.req, jam});
      end
   endtask : quiet

   // one receive event, then length of the jam it caused
   task automatic jam_len(input logic pre, input logic [2:0] cls, output int l);
      int n;
      rx <= '{preamble: pre, addr_done: !pre, mcast: cls[2], bcast: cls[1], own_match: cls[0]};
      @(posedge clk);
      rx <= '0;
      n = 0;
      while (jam !== 1'b1 && n < 5) begin
         @(posedge clk);
         n++;
      end
      l = 0;
      while (jam === 1'b1 && l < 3000) begin
         l++;
         @(posedge clk);
      end
   endtask : jam_len

   function automatic int jam_exp(input logic [3:0] c, input logic slow);
      int u;
      u = (c < 4) ? ((c == 3) ? 5 : c + 1) : (c - 3) * 10;
      return u * UNIT + (slow ? EXTRA : 0);
   endfunction : jam_exp

   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      apb(0, `AUTO_FLOW_CONTROL_CONFIG_OFS, 0);
      chk("cfg reset", 0, q);
      apb(0, `AFC_PTIME_OFS, 0);
      chk("pause time reset", 0, q);
      apb(0, 12'h0f0, 0);
      chk("unmapped error", 1, e);
      chk("unmapped data", 0, q);
      repeat (4) begin
         d = $random(seed);
         apb(1, `AUTO_FLOW_CONTROL_CONFIG_OFS, d);
         apb(0, `AUTO_FLOW_CONTROL_CONFIG_OFS, 0);
         chk("cfg", d & 32'h00ffffff, q);
      end
      pstrb <= 4'h6;
      apb(1, `AUTO_FLOW_CONTROL_CONFIG_OFS, ~d);
      pstrb <= 4'hf;
      apb(0, `AUTO_FLOW_CONTROL_CONFIG_OFS, 0);
      chk("cfg strobed", {8'h00, ~d[23:8], d[7:0]}, q);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      apb(0, `AUTO_FLOW_CONTROL_CONFIG_OFS, 0);
      chk("cfg after reset", 0, q);
      apb(0, `AFC_STAT_OFS, 0);
      chk("status after reset", 32'h00040000, q);
      $display("test registers done");
      // full duplex pause then zero-time resume
      t = 16'($random(seed));
      dly <= 4'($random(seed)) & 4'h3;
      apb(1, `AFC_PTIME_OFS, {16'h0, t});
      apb(1, `AUTO_FLOW_CONTROL_CONFIG_OFS, 32'h00010101);
      fdx <= 1'b1;
      txen <= 1'b1;
      quiet(10);
      pulse_fifo(16'd61, 0);
      wait_req(t);
      apb(0, `AFC_STAT_OFS, 0);
      chk("fifo level", 64, q[15:0]);
      chk("paused flag", 1, q[16]);
      pulse_fifo(16'd64, 0);
      quiet(20);
      pulse_fifo(0, 16'd40);
      quiet(10);
      pulse_fifo(0, 16'd25);
      wait_req(0);
      apb(0, `AFC_STAT_OFS, 0);
      chk("paused flag", 0, q[16]);
      pulse_fifo(0, 16'd60);
      quiet(10);
      txen <= 1'b0;
      pulse_fifo(16'd200, 0);
      quiet(10);
      txen <= 1'b1;
      wait_req(t);
      pulse_fifo(0, 16'hffff);
      wait_req(0);
      apb(1, `AUTO_FLOW_CONTROL_CONFIG_OFS, 32'h000000fe);
      jam_len(0, 3'b111, len);
      chk("full duplex jam", 0, len);
      quiet(5);
      $display("test full duplex done");
      // half duplex jam durations
      fdx <= 1'b0;
      for (int c = 0; c < 16; c++) begin
         apb(1, `AUTO_FLOW_CONTROL_CONFIG_OFS, {24'h0, 4'(c), 4'h1});
         jam_len(1, 0, len);
         chk("jam length", jam_exp(4'(c), 0), len);
      end
      spd <= 1'b0;
      for (int c = 0; c < 16; c += 15) begin
         apb(1, `AUTO_FLOW_CONTROL_CONFIG_OFS, {24'h0, 4'(c), 4'h1});
         jam_len(1, 0, len);
         chk("slow jam length", jam_exp(4'(c), 1), len);
      end
      spd <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         d = (i < 3) ? (32'h8 >> i) : 32'($random(seed)) & 32'he;
         t = (i < 3) ? (16'h4 >> i) : 16'($random(seed)) & 16'h7;
         apb(1, `AUTO_FLOW_CONTROL_CONFIG_OFS, d);
         jam_len(0, t[2:0], len);
         chk("class jam", ((d[3:1] & t[2:0]) != 0) ? jam_exp(0, 0) : 0, len);
      end
      apb(1, `AUTO_FLOW_CONTROL_CONFIG_OFS, 32'h0000000f);
      jam_len(0, 3'b111, len);
      chk("any overrides class", 0, len);
      apb(1, `AUTO_FLOW_CONTROL_CONFIG_OFS, 32'h000000f1);
      rx <= '{preamble: 1'b1, default: 1'b0};
      @(posedge clk);
      rx <= '0;
      @(posedge clk);
      apb(0, `AFC_STAT_OFS, 0);
      chk("jam and threshold status", 32'h6, q[18:16]);
      apb(1, `AUTO_FLOW_CONTROL_CONFIG_OFS, 32'h00000011);
      rx <= '{preamble: 1'b1, default: 1'b0};
      @(posedge clk);
      rx <= '0;
      repeat (2) @(posedge clk);
      jam_len(1, 0, len);
      chk("restarted jam", jam_exp(1, 0) + 2, len);
      txen <= 1'b0;
      jam_len(1, 0, len);
      chk("jam while tx off", 0, len);
      $display("test half duplex done");
      report_and_stop();
   end
endmodule : rx_fifo_flow_control_bench
`default_nettype wire
